// File: prf_map.svh
// Constants for the pin routing fabric: selector codes, key bytes, counts.
// Assumes inclusion by the pin routing package and design modules only.
`ifndef PRF_MAP_SVH
`define PRF_MAP_SVH

`define PRF_NUM_PINS      18
`define PRF_NUM_INSEL     32
`define PRF_SEL_W         6
`define PRF_NUM_SRC       33
`define PRF_KEY_FIRST     8'h55
`define PRF_KEY_SECOND    8'hAA
`define PRF_KEY_WINDOW    3'h5
`define PRF_LOCK_BIT      0
`define PRF_OUT_RESET     6'h00
`define PRF_IN_RESET      6'h00
`define PRF_CODE_FIRST    6'h01
`define PRF_CODE_LAST     6'h20
`define PRF_CODE_TX_CK    6'h0F
`define PRF_CODE_DT       6'h10
`define PRF_CODE_S1_CK    6'h13
`define PRF_CODE_S1_DO    6'h14
`define PRF_CODE_S2_CK    6'h15
`define PRF_CODE_S2_DO    6'h16
`define PRF_PORT_LSB      3

`endif

// File: prf_out_mux.sv
// One pin's output multiplexer: selects a peripheral output or port latch.
// Assumes a packed source vector whose bit n is the peripheral with code n.
`timescale 1ns/1ps
`include "prf_map.svh"

module prf_out_mux (
   input  wire logic                       big_variant, // 20-pin part present.
   input  wire prf_pkg::prf_sel_t          sel,         // Stored source code.
   input  wire logic [`PRF_NUM_SRC-1:0]    src,         // Peripheral outputs.
   input  wire logic                       latch_bit,   // Port data latch.
   output logic                            pin_out      // Routed pin level.
);
   wire in_range;
   wire s2_code;
   wire use_src;

   // Codes outside the table, zero and 20-pin-only codes on small parts
   // fall back to the port data latch.
   assign in_range = (sel >= `PRF_CODE_FIRST) && (sel <= `PRF_CODE_LAST);
   assign s2_code  = (sel == `PRF_CODE_S2_CK) || (sel == `PRF_CODE_S2_DO);
   assign use_src  = in_range && !(s2_code && !big_variant); // [R6] [R19]

   // The same code table serves every pin.
   assign pin_out = use_src ? src[sel] : latch_bit; // [R2] [R4] [R5]
endmodule

// File: prf_periph_model.sv
// Peripheral and pad side model: every output is redrawn at random each cycle.
// Assumes the bench samples the routed results after the falling edge.
`timescale 1ns/1ps
module prf_periph_model (
   input  wire logic   mclk,       // Clock.
   output logic [32:0] periph_out, // Peripheral outputs.
   output logic [17:0] port_latch, // Port latches.
   output logic [17:0] pin_in      // Pad levels.
);
   // Fresh levels at each falling edge so a stale route shows up.
   initial forever begin
      periph_out = 33'({$urandom, $urandom});
      port_latch = 18'($urandom);
      pin_in = 18'($urandom);
      @(negedge mclk);
   end
endmodule

// File: prf_pkg.sv
// Types shared by the pin routing fabric modules.
// Assumes prf_map.svh is available on the include path.
`include "prf_map.svh"

package prf_pkg;
   typedef logic [`PRF_SEL_W-1:0] prf_sel_t;
   typedef enum logic [1:0] {
      PRF_KEY_IDLE,
      PRF_KEY_GOT_FIRST,
      PRF_KEY_OPEN
   } prf_key_state_t;
endpackage

// File: prf_properties.sv
// Checker for the pin routing fabric: lock, freeze, reset and pin relations.
// Assumes a multi-cycle srst and one-cycle write strobes at the top ports.
`timescale 1ns/1ps
module prf_properties (
   input wire logic        mclk,                   // Clock.
   input wire logic        srst,                   // Reset.
   input wire logic        one_time_lock_config,   // Option.
   input wire logic        wr_strobe,              // Write pulse.
   input wire logic        wr_lock_reg,            // Lock target.
   input wire logic        wr_out_sel,             // Output target.
   input wire logic [7:0]  wr_data,                // Write data.
   input wire logic [4:0]  rd_out_index,           // Read index.
   input wire logic [17:0] port_latch,             // Latches.
   input wire logic [17:0] port_direction_control, // Direction.
   input wire logic        serial_dir_req,         // Override.
   input wire logic [17:0] pin_out,                // Pin data.
   input wire logic [17:0] pin_oe,                 // Pin enables.
   input wire logic [7:0]  rd_out_data,            // Read data.
   input wire logic        routing_locked_bit      // Lock state.
);
   logic [7:0] w1_reg, w2_reg, w3_reg;
   logic       fresh_reg, fell_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // Keeps the last three writes and whether a one-time clear happened.
   always_ff @(posedge mclk) begin
      if (srst) begin
         {w1_reg, w2_reg, w3_reg} <= 24'h000000;
         fresh_reg <= 1'b1;
         fell_reg <= 1'b0;
      end else begin
         if (wr_strobe) {w1_reg, w2_reg, w3_reg} <=
            {(wr_lock_reg ? wr_data : 8'h00), w1_reg, w2_reg};
         if (wr_strobe && wr_out_sel) fresh_reg <= 1'b0;
         if (one_time_lock_config && $fell(routing_locked_bit))
            fell_reg <= 1'b1;
      end
   end
   // A lock change copies bit 0 of a lock write.
   property p_lock_src; !$past(srst) && $changed(routing_locked_bit) |->
      $past(wr_strobe && wr_lock_reg) &&
      $past(wr_data[0]) == routing_locked_bit;
   endproperty
   a_lock_src: assert property (p_lock_src)
      else $error("Lock moved without a lock write.");
   property p_keys; !$past(srst) && $changed(routing_locked_bit) |->
      w2_reg == 8'hAA && w3_reg == 8'h55; endproperty
   a_keys: assert property (p_keys)
      else $error("Lock moved without the key pair.");
   property p_frozen; $past(routing_locked_bit) && routing_locked_bit &&
      $stable(rd_out_index) |=> $stable(rd_out_data); endproperty
   a_frozen: assert property (p_frozen)
      else $error("Selector changed while locked.");
   property p_latch; fresh_reg |-> pin_out == port_latch; endproperty
   a_latch: assert property (p_latch)
      else $error("Default selection is not the port latch.");
   property p_oe; !serial_dir_req |-> pin_oe == ~port_direction_control;
   endproperty
   a_oe: assert property (p_oe)
      else $error("Pin enable differs from direction control.");
   property p_once; fell_reg |-> !$fell(routing_locked_bit); endproperty
   a_once: assert property (p_once)
      else $error("Second clear accepted under one-time option.");
   property p_por; disable iff (1'b0)
      srst |=> !routing_locked_bit && rd_out_data == 8'h00; endproperty
   a_por: assert property (p_por)
      else $error("Reset left lock or selector set.");
   property p_fresh; fresh_reg |-> rd_out_data == 8'h00; endproperty
   a_fresh: assert property (p_fresh)
      else $error("Selector not zero after reset.");
   c_set: cover property ($rose(routing_locked_bit));
   c_clear: cover property ($fell(routing_locked_bit));
   c_routed: cover property (!fresh_reg && pin_out != port_latch);
endmodule
bind prf_top prf_properties u_props (.mclk, .srst, .one_time_lock_config,
   .wr_strobe, .wr_lock_reg, .wr_out_sel, .wr_data, .rd_out_index,
   .port_latch, .port_direction_control, .serial_dir_req, .pin_out,
   .pin_oe, .rd_out_data, .routing_locked_bit);

// File: prf_top.sv
// Pin routing fabric: per-pin output selectors, input selectors and the
// key-guarded routing lock with its one-time option.
// Assumes a CPU side that issues one-cycle write strobes with byte data,
// peripherals presenting outputs as a code-indexed vector, and a
// power-on reset kept separate from the other reset sources.
//
// Summary of operation
// [R1] Every pin has its own output source selector.
// [R2] Same source code table for every pin.
// [R3] Serial peripherals may override pin direction control.
// [R4] Codes 1 to 32 pick distinct peripheral outputs.
// [R5] Serial port clock and data codes fixed.
// [R6] Second serial port codes only on 20-pin; on small parts they still select the serial direction override.
// [R7] Software maps bidirectional input and output together.
// [R8] Lock freezes all selectors against writes.
// [R9] Lock change needs 0x55, 0xAA key first.
// [R10] Lock change without fresh key is rejected.
// [R11] One-time option allows one clear/set per reset.
// [R12] Without option, lock toggles freely with key.
// [R13] Selectors stay readable whatever the lock state.
// [R14] Sleep leaves all selections untouched.
// [R15] Only power-on reset restores default selections.
// [R16] Power-on reset also clears one-time-lock history.
// [R17] Software masks interrupts around key sequence.
// [R18] Input code: port upper bits, pin low three.
// [R19] Unassigned codes drive the port data latch.
// [R20] Locked selector writes are silently dropped.
`timescale 1ns/1ps
`include "prf_map.svh"

module prf_top (
   input  wire logic                          mclk,          // System clock.
   input  wire logic                          srst,          // Power-on reset.
   input  wire logic                          other_reset,   // Other resets.
   input  wire logic                          sleep_mode,    // Device asleep.
   input  wire logic                          one_time_lock_config, // Option.
   input  wire logic                          big_variant,   // 20-pin part.
   input  wire logic                          wr_strobe,     // Write pulse.
   input  wire logic                          instr_tick,    // Instr. retired.
   input  wire logic                          wr_lock_reg,   // Target: lock.
   input  wire logic                          wr_out_sel,    // Target: output.
   input  wire logic                          wr_in_sel,     // Target: input.
   input  wire logic [4:0]                    wr_index,      // Selector index.
   input  wire logic [7:0]                    wr_data,       // Write data.
   input  wire logic [4:0]                    rd_out_index,  // Output read.
   input  wire logic [4:0]                    rd_in_index,   // Input read.
   input  wire logic [`PRF_NUM_SRC-1:0]       periph_out,    // Peripheral outs.
   input  wire logic [`PRF_NUM_PINS-1:0]      port_latch,    // Port latches.
   input  wire logic [`PRF_NUM_PINS-1:0]      port_direction_control, // Dir.
   input  wire logic [`PRF_NUM_PINS-1:0]      pin_in,        // Pin levels.
   input  wire logic                          serial_dir_req, // Serial drives.
   input  wire logic                          serial_dir_val, // Dir it wants.
   output logic [`PRF_NUM_PINS-1:0]           pin_out,       // Pin data out.
   output logic [`PRF_NUM_PINS-1:0]           pin_oe,        // Pin enable.
   output logic [`PRF_NUM_INSEL-1:0]          periph_in,     // Routed inputs.
   output logic [7:0]                         rd_out_data,   // Output sel read.
   output logic [7:0]                         rd_in_data,    // Input sel read.
   output logic [7:0]                         routing_lock_register, // Lock.
   output logic                               routing_locked_bit // Lock state.
);
   prf_pkg::prf_sel_t       out_sel_reg [`PRF_NUM_PINS];
   prf_pkg::prf_sel_t       in_sel_reg  [`PRF_NUM_INSEL];
   prf_pkg::prf_key_state_t key_state_reg;
   prf_pkg::prf_key_state_t key_state_next;
   logic [2:0]              key_count_reg;
   logic [2:0]              key_count_next;
   logic                    locked_reg;
   logic                    locked_next;
   logic                    one_time_used_reg;
   logic                    one_time_used_next;
   logic [`PRF_NUM_PINS-1:0] dir_override;

   wire lock_write;
   wire key_window_open;
   wire want_lock;
   wire lock_change;
   wire lock_allowed;
   wire sel_write_ok;

   // Maps an input selector code to a pin index, or flags it as unused.
   // The port field takes every bit above the pin number, so codes with the
   // top bit set land beyond the last pin and read low.
   function automatic logic [5:0] prf_pin_index(input prf_pkg::prf_sel_t c);
      logic [2:0] port;
      port = c[`PRF_SEL_W-1:`PRF_PORT_LSB]; // [R18]
      prf_pin_index = {port, c[2:0]};
   endfunction

   // Lock register write decoding and permission.
   assign lock_write      = wr_strobe && wr_lock_reg;
   assign key_window_open = (key_state_reg == prf_pkg::PRF_KEY_OPEN);
   assign want_lock       = wr_data[`PRF_LOCK_BIT];
   assign lock_change     = lock_write && key_window_open; // [R9] [R10]
   // With the one-time option a release is allowed once; a set always is.
   assign lock_allowed    = want_lock ||
                            !(one_time_lock_config && one_time_used_reg);
   // Locked writes drop quietly; sleep does not alter the selectors.
   assign sel_write_ok    = wr_strobe && !locked_reg; // [R8] [R20] [R14]

   // Key recognition: 0x55, then 0xAA, opens a short instruction window.
   always_comb begin
      key_state_next = key_state_reg;
      key_count_next = key_count_reg;
      if (lock_write) begin
         if (key_state_reg == prf_pkg::PRF_KEY_GOT_FIRST &&
             wr_data == `PRF_KEY_SECOND) begin
            key_state_next = prf_pkg::PRF_KEY_OPEN; // [R9]
            key_count_next = 3'h0;
         end else if (wr_data == `PRF_KEY_FIRST) begin
            key_state_next = prf_pkg::PRF_KEY_GOT_FIRST;
            key_count_next = 3'h0;
         end else begin
            key_state_next = prf_pkg::PRF_KEY_IDLE; // [R10]
         end
      end else if (wr_strobe) begin
         // Any other write breaks the sequence.
         key_state_next = prf_pkg::PRF_KEY_IDLE; // [R10]
      end else if (instr_tick) begin
         if (key_count_reg == `PRF_KEY_WINDOW - 3'h1) begin
            key_state_next = prf_pkg::PRF_KEY_IDLE; // [R9]
         end else begin
            key_count_next = key_count_reg + 3'h1;
         end
      end
   end

   // Lock bit and one-time history.
   always_comb begin
      locked_next        = locked_reg;
      one_time_used_next = one_time_used_reg;
      if (lock_change && lock_allowed) begin
         locked_next = want_lock; // [R11] [R12]
         if (!want_lock) begin
            one_time_used_next = 1'b1; // [R11]
         end
      end
   end

   // Key and lock state; only power-on reset restores them.
   always_ff @(posedge mclk) begin
      if (srst) begin
         key_state_reg     <= prf_pkg::PRF_KEY_IDLE;
         key_count_reg     <= 3'h0;
         locked_reg        <= 1'b0;
         one_time_used_reg <= 1'b0; // [R16]
      end else begin
         key_state_reg     <= key_state_next;
         key_count_reg     <= key_count_next;
         locked_reg        <= locked_next;
         one_time_used_reg <= one_time_used_next;
      end
   end

   // Selector storage and routing, one slice per pin and one per peripheral input.
   genvar g;
   generate
      for (g = 0; g < `PRF_NUM_PINS; g++) begin : g_pin
         // Output selector for this pin; other resets leave it alone.
         always_ff @(posedge mclk) begin
            if (srst) begin
               out_sel_reg[g] <= `PRF_OUT_RESET; // [R15]
            end else if (sel_write_ok && wr_out_sel &&
                         wr_index == 5'(g)) begin
               out_sel_reg[g] <= wr_data[`PRF_SEL_W-1:0]; // [R1] [R8]
            end
         end

         prf_out_mux u_mux (
            .big_variant (big_variant),
            .sel         (out_sel_reg[g]),
            .src         (periph_out),
            .latch_bit   (port_latch[g]),
            .pin_out     (pin_out[g])
         );

         // Serial peripherals take over direction on their own pins.
         assign dir_override[g] = serial_dir_req &&
            ((out_sel_reg[g] == `PRF_CODE_DT) ||
             (out_sel_reg[g] == `PRF_CODE_S1_CK) ||
             (out_sel_reg[g] == `PRF_CODE_S1_DO) ||
             (out_sel_reg[g] == `PRF_CODE_S2_CK) ||
             (out_sel_reg[g] == `PRF_CODE_S2_DO)); // [R3]
         // Direction control is high for input, so enable is its inverse.
         assign pin_oe[g] = dir_override[g] ? serial_dir_val
                                            : !port_direction_control[g];
      end

      for (g = 0; g < `PRF_NUM_INSEL; g++) begin : g_in
         logic [5:0] idx;
         // Input selector for one peripheral input.
         always_ff @(posedge mclk) begin
            if (srst) begin
               in_sel_reg[g] <= `PRF_IN_RESET; // [R15]
            end else if (sel_write_ok && wr_in_sel &&
                         wr_index == 5'(g)) begin
               in_sel_reg[g] <= wr_data[`PRF_SEL_W-1:0]; // [R8]
            end
         end
         // Unused codes read as low.
         assign idx = prf_pin_index(in_sel_reg[g]);
         assign periph_in[g] = (idx < 6'(`PRF_NUM_PINS)) ?
                               pin_in[idx[4:0]] : 1'b0; // [R18]
      end
   endgenerate

   // Read paths are open whatever the lock state.
   always_ff @(posedge mclk) begin
      if (srst) begin
         rd_out_data <= 8'h00;
         rd_in_data  <= 8'h00;
      end else begin
         rd_out_data <= (rd_out_index < 5'(`PRF_NUM_PINS)) ?
                        {2'h0, out_sel_reg[rd_out_index]} : 8'h00; // [R13]
         rd_in_data  <= {2'h0, in_sel_reg[rd_in_index]}; // [R13]
      end
   end

   // Lock register view: only bit zero is implemented.
   assign routing_locked_bit    = locked_reg;
   assign routing_lock_register = {7'h00, locked_reg};

   // Signals present for completeness of the reset model.
   wire unused_ok;
   assign unused_ok = other_reset | sleep_mode; // [R14] [R15]
endmodule

// File: tb_top.sv
// Self-checking bench for the pin routing fabric with a reference model.
// Assumes prf_top, the bound checker and the peripheral model.
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0, srst = 1'b1, other_reset = 1'b0, sleep_mode = 1'b0;
   logic one_time_lock_config = 1'b0, big_variant = 1'b0, wr_strobe = 1'b0;
   logic instr_tick = 1'b0, wr_lock_reg = 1'b0, wr_out_sel = 1'b0;
   logic wr_in_sel = 1'b0, serial_dir_req = 1'b0, serial_dir_val = 1'b0;
   logic [4:0]  wr_index = 5'h00, rd_out_index = 5'h00, rd_in_index = 5'h00;
   logic [7:0]  wr_data = 8'h00, rd_out_data, rd_in_data;
   logic [7:0]  routing_lock_register;
   logic [17:0] port_direction_control = 18'h00000, port_latch, pin_in;
   logic [17:0] pin_out, pin_oe;
   logic [32:0] periph_out;
   logic [31:0] periph_in;
   logic        routing_locked_bit;
   int          miscompares = 0, compares = 0;
   int          osel[18], isel[32], lk, once, ks, i, p, c;
   logic        ov, exp_bit;
   logic [17:0] oe_exp;
   prf_top DUT (.*);
   prf_periph_model u_far (.*);
   initial forever #4 mclk = ~mclk;
   // Random side inputs; sleep and other resets must change nothing.
   initial forever begin
      @(negedge mclk);
      {big_variant, sleep_mode, other_reset, serial_dir_val,
       serial_dir_req} = 5'($urandom);
      port_direction_control = 18'($urandom);
   end
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Compares pins, routed inputs, lock and one read of each table.
   task automatic chk();
      #2;
      for (p = 0; p < 18; p++) begin
         c = osel[p];
         // Sync data and both serial ports may take over the driver.
         ov = serial_dir_req && (c == 16 || (c > 18 && c < 23));
         oe_exp[p] = ov ? serial_dir_val : !port_direction_control[p];
         exp_bit = (c > 0 && c < 33 && (big_variant || c < 21 || c > 22)) ?
                   periph_out[c] : port_latch[p];
         cmp("pin_out", exp_bit, pin_out[p]);
      end
      for (p = 0; p < 32; p++) begin
         exp_bit = isel[p] < 18 ? pin_in[isel[p]] : 1'b0;
         cmp("periph_in", exp_bit, periph_in[p]);
      end
      cmp("pin_oe", oe_exp, pin_oe);
      cmp("locked", lk, routing_locked_bit);
      cmp("lock_reg", lk, routing_lock_register);
      rd_out_index = 5'($urandom_range(17));
      rd_in_index = 5'($urandom_range(31));
      @(negedge mclk) #2;
      cmp("rd_out", osel[rd_out_index], rd_out_data);
      cmp("rd_in", isel[rd_in_index], rd_in_data);
   endtask
   // One write; t is 4 for lock, 2 for output, 1 for input selectors.
   task automatic wr(int t, int idx, int d);
      @(negedge mclk);
      {wr_lock_reg, wr_out_sel, wr_in_sel} = 3'(t);
      wr_index = 5'(idx);
      wr_data = 8'(d);
      wr_strobe = 1'b1;
      if (t == 4 && ks == 2) begin
         if (d[0]) lk = 1;
         else if (!(one_time_lock_config && once)) begin
            lk = 0;
            once = once | one_time_lock_config;
         end
         ks = 0;
      end else if (t == 4) ks = d == 'h55 ? 1 : (ks == 1 && d == 'hAA) ? 2 : 0;
      else begin
         ks = 0;
         if (!lk && t == 2) osel[idx] = d & 63;
         if (!lk && t == 1) isel[idx] = d & 63;
      end
      @(negedge mclk);
      wr_strobe = 1'b0;
   endtask
   task automatic key(int d, int n);
      wr(4, 0, 'h55);
      wr(4, 0, 'hAA);
      repeat (n) begin
         @(negedge mclk) instr_tick = 1'b1;
         @(negedge mclk) instr_tick = 1'b0;
      end
      // The fifth retired instruction closes the key window.
      if (n > 4) ks = 0;
      wr(4, 0, d);
      chk();
   endtask
   task automatic rst(logic cfg);
      srst = 1'b1;
      one_time_lock_config = cfg;
      repeat (4) @(negedge mclk);
      srst = 1'b0;
      osel = '{default: 0};
      isel = '{default: 0};
      lk = 0;
      once = 0;
      ks = 0;
      chk();
   endtask
   initial begin
      #200000 miscompares++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h3360));
      rst(1'b0);
      for (i = 0; i < 35; i++) begin
         wr(2, $urandom_range(17), i | ($urandom_range(3) << 6));
         chk();
      end
      for (i = 0; i < 32; i++) begin
         wr(1, i, $urandom_range(63));
         chk();
      end
      // Sync data routed out of and back into the same pin.
      wr(2, 5, 'h10);
      wr(1, 7, 5);
      chk();
      wr(4, 0, 1);
      chk();
      wr(4, 0, 'h55);
      wr(2, 0, 5);
      wr(4, 0, 'hAA);
      wr(4, 0, 1);
      chk();
      key(1, 2);
      wr(2, 3, 9);
      wr(1, 3, 9);
      chk();
      key(0, 5);
      key(0, 4);
      for (i = 0; i < 4; i++) key(~i & 1, 0);
      rst(1'b1);
      for (i = 0; i < 4; i++) key(~i & 1, 0);
      wr(2, 1, 7);
      chk();
      rst(1'b1);
      key(1, 0);
      key(0, 0);
      report_and_stop();
   end
endmodule
